//--- design/lps_pkg.sv
// Package for the LED pattern sequencer: offsets, fields, timing tables, types
package lps_pkg;

   // Register offsets on the register port
   localparam logic [7:0] LPS_ADDR_TIMING = 8'h18;   // On/off time codes
   localparam logic [7:0] LPS_ADDR_PULSE  = 8'h19;   // Repeat count and pause
   localparam logic [7:0] LPS_ADDR_SKIP   = 8'h1A;   // Per-output frame mask
   localparam logic [7:0] LPS_ADDR_START  = 8'h1B;   // Start control
   localparam logic [7:0] LPS_ADDR_OFFSET = 8'h1C;   // Per-output start delay

   // Reset values
   localparam logic [2:0] LPS_RST_TOFF = 3'h3;       // Off-time code default
   localparam logic [2:0] LPS_RST_TON  = 3'h0;       // On-time code default
   localparam logic       LPS_RST_SRC  = 1'h1;       // Trigger source: pin

   // Field positions in the start control register
   localparam int LPS_BIT_SRC   = 0;                 // Trigger source
   localparam int LPS_BIT_EN    = 1;                 // Write-only run enable
   localparam int LPS_BIT_PHASE = 2;                 // Graceful stop select
   localparam int LPS_BIT_BUSY  = 3;                 // Read-only running flag

   // Timing base: one millisecond at a 25 ns clock
   localparam int LPS_CLK_PERIOD_NS = 25;            // Clock period
   localparam int LPS_TICK_NS       = 1000000;       // Time unit of the tables
   localparam int LPS_TICK_CYCLES   = LPS_TICK_NS / LPS_CLK_PERIOD_NS;

   // Durations in milliseconds, indexed by code
   localparam logic [13:0] LPS_ON_MS [8] = '{14'h0028, 14'h0046, 14'h008C, 14'h010E,
                                             14'h0212, 14'h044C, 14'h0834, 14'h1068};
   localparam logic [13:0] LPS_OFF_MS [8] = '{14'h0050, 14'h0096, 14'h0118, 14'h021C,
                                              14'h044C, 14'h0834, 14'h1068, 14'h20D0};
   localparam logic [13:0] LPS_GAP_MS [4] = '{14'h0000, 14'h0096, 14'h0118, 14'h021C};

   localparam int LPS_NCH = 4;                       // Output channels

   // Software-visible configuration
   typedef struct packed {
      logic [2:0]       toff;                        // Off-time code
      logic [2:0]       ton;                         // On-time code
      logic [1:0]       pulses;                      // Pulses per frame minus one
      logic [1:0]       gap;                         // Pause code
      logic [3:0][1:0]  skip;                        // Frames masked per output
      logic [3:0][1:0]  offset;                      // Start delay per output
      logic             phase_out;                   // Finish frame on stop
      logic             src;                         // 1: pin triggers
   } lps_cfg_type;

   // Sequencer phases
   typedef enum logic [1:0] {
      LPS_IDLE,
      LPS_ON,
      LPS_PAUSE,
      LPS_OFF
   } lps_state_type;

endpackage

//--- design/lps_tick.sv
// Millisecond enable pulse divider for the LED pattern sequencer
`timescale 1ns/10ps
`default_nettype none
module lps_tick
   import lps_pkg::*;
#(
   parameter int TICK_CYCLES = LPS_TICK_CYCLES       // Cycles per tick
) (
   input  wire logic i_clk,                          // 40 MHz clock
   input  wire logic i_rst,                          // Async reset, high
   input  wire logic i_clr,                          // Restart the period
   output var  logic o_tick                          // One-cycle enable
);

   localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1); // Terminal count

   logic [15:0] cnt_q;                               // Cycle counter
   logic [15:0] cnt_d;
   logic        tick_d;

   // Next count; restart lines the first tick up with a phase start
   always_comb begin
      cnt_d  = cnt_q + 16'h0001;
      tick_d = 1'b0;
      if (i_clr) begin
         cnt_d = 16'h0000;
      end else if (cnt_q == LAST) begin
         cnt_d  = 16'h0000;
         tick_d = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         o_tick <= tick_d;
      end
   end

endmodule
`default_nettype wire

//--- design/lps_top.sv
// LED pattern sequencer: registers, frame sequencer and per-output masking
`timescale 1ns/10ps
`default_nettype none
module lps_top
   import lps_pkg::*;
#(
   parameter int TICK_CYCLES = LPS_TICK_CYCLES       // Cycles per millisecond
) (
   input  wire logic       i_clk,                    // 40 MHz clock
   input  wire logic       i_rst,                    // Async reset, high
   input  wire logic       i_reg_wr,                 // Register write strobe
   input  wire logic [7:0] i_reg_addr,               // Register offset
   input  wire logic [7:0] i_reg_wdata,              // Write data
   input  wire logic       i_trig_pin,               // External trigger pin
   output var  logic [7:0] o_reg_rdata,              // Read data, one cycle late
   output var  logic [3:0] o_led_output,             // Output on, bit per output
   output var  logic       o_running                 // Pattern running
);

   // Configuration registers
   lps_cfg_type cfg_q;                               // Stored settings
   lps_cfg_type cfg_d;
   logic        en_q;                                // Write-only run enable
   logic        en_d;
   logic [7:0]  rdata_d;                             // Next read data

   // Trigger pin synchroniser
   logic [2:0]  pin_s_q;                             // Three stages
   logic        pin_q;                               // Accepted level
   logic        pin_d;

   // Sequencer state
   lps_state_type              state_q;              // Phase
   lps_state_type              state_d;
   logic [13:0]                ms_q;                 // Elapsed ms in phase
   logic [13:0]                ms_d;
   logic [1:0]                 pulse_q;              // Pulse index in frame
   logic [1:0]                 pulse_d;
   logic [LPS_NCH-1:0][1:0]    dly_q;                // Frames left to wait
   logic [LPS_NCH-1:0][1:0]    dly_d;
   logic [LPS_NCH-1:0][1:0]    skp_q;                // Position in mask cycle
   logic [LPS_NCH-1:0][1:0]    skp_d;
   logic [LPS_NCH-1:0]         act_d;                // Output lit this frame
   logic [3:0]                 led_d;

   logic        tick;                                // Millisecond enable
   logic        run_req;                             // Selected start request
   logic        start;                               // Leaving idle
   logic        frame_end;                           // Last ms of the off-time
   logic        done;                                // Current phase expires
   logic [13:0] dur;                                 // Current phase length

   // Divider restarts with each pattern so the first on-time is whole
   lps_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_clr  (start),
      .o_tick (tick)
   );

   // Register writes and read mux
   always_comb begin
      cfg_d   = cfg_q;
      en_d    = en_q;
      rdata_d = 8'h00;                               // Unmapped reads give zero
      if (i_reg_wr) begin
         case (i_reg_addr)
            LPS_ADDR_TIMING: begin
               cfg_d.toff = i_reg_wdata[5:3];
               cfg_d.ton  = i_reg_wdata[2:0];
            end
            LPS_ADDR_PULSE: begin
               cfg_d.pulses = i_reg_wdata[7:6];
               cfg_d.gap    = i_reg_wdata[1:0];
            end
            LPS_ADDR_SKIP: begin
               cfg_d.skip = i_reg_wdata;
            end
            LPS_ADDR_START: begin
               cfg_d.phase_out = i_reg_wdata[LPS_BIT_PHASE];
               en_d            = i_reg_wdata[LPS_BIT_EN];
               cfg_d.src       = i_reg_wdata[LPS_BIT_SRC];
            end
            LPS_ADDR_OFFSET: begin
               cfg_d.offset = i_reg_wdata;
            end
            default: begin
            end
         endcase
      end
      case (i_reg_addr)
         LPS_ADDR_TIMING: rdata_d = {2'h0, cfg_q.toff, cfg_q.ton};
         LPS_ADDR_PULSE:  rdata_d = {cfg_q.pulses, 4'h0, cfg_q.gap};
         LPS_ADDR_SKIP:   rdata_d = cfg_q.skip;
         LPS_ADDR_START: begin
            // Enable bit is write-only and reads zero; busy shows the sequencer
            rdata_d[LPS_BIT_PHASE] = cfg_q.phase_out;
            rdata_d[LPS_BIT_SRC]   = cfg_q.src;
            rdata_d[LPS_BIT_BUSY]  = (state_q != LPS_IDLE);
         end
         LPS_ADDR_OFFSET: rdata_d = cfg_q.offset;
         default:         rdata_d = 8'h00;
      endcase
   end

   // Pin level accepted only when the last two stages agree
   always_comb begin
      pin_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_q;
   end

   // Start request and phase timing
   always_comb begin
      run_req = cfg_q.src ? pin_q : en_q;
      start   = (state_q == LPS_IDLE) && run_req;
      case (state_q)
         LPS_ON:    dur = LPS_ON_MS[cfg_q.ton];
         LPS_PAUSE: dur = LPS_GAP_MS[cfg_q.gap];
         LPS_OFF:   dur = LPS_OFF_MS[cfg_q.toff];
         default:   dur = 14'h0000;
      endcase
      // At-or-past compare: a code shortened mid-phase ends it at the next tick
      done      = tick && ((ms_q + 14'h0001) >= dur);
      frame_end = (state_q == LPS_OFF) && done;
   end

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      ms_d    = tick ? ms_q + 14'h0001 : ms_q;
      pulse_d = pulse_q;
      case (state_q)
         LPS_IDLE: begin
            ms_d = 14'h0000;
            if (run_req) begin
               state_d = LPS_ON;
               pulse_d = 2'h0;
            end
         end
         LPS_ON: begin
            if (done) begin
               ms_d = 14'h0000;
               if (pulse_q == cfg_q.pulses) begin
                  state_d = LPS_OFF;
               end else if (cfg_q.gap == 2'h0) begin // Zero pause: back to back
                  pulse_d = pulse_q + 2'h1;
               end else begin
                  state_d = LPS_PAUSE;
               end
            end
         end
         LPS_PAUSE: begin
            if (done) begin
               ms_d    = 14'h0000;
               state_d = LPS_ON;
               pulse_d = pulse_q + 2'h1;
            end
         end
         LPS_OFF: begin
            if (done) begin
               ms_d    = 14'h0000;
               pulse_d = 2'h0;
               // Graceful stop ends here, after the whole frame
               state_d = run_req ? LPS_ON : LPS_IDLE;
            end
         end
         default: begin
            state_d = LPS_IDLE;
         end
      endcase
      // Immediate stop overrides everything
      if (!run_req && !cfg_q.phase_out) begin
         state_d = LPS_IDLE;
      end
   end

   // Per-output delay and mask counters
   for (genvar ch = 0; ch < LPS_NCH; ch++) begin : g_ch
      always_comb begin
         dly_d[ch] = dly_q[ch];
         skp_d[ch] = skp_q[ch];
         if (start) begin
            // Delays are caught only here, so later writes wait a restart
            dly_d[ch] = cfg_q.offset[ch];
            skp_d[ch] = 2'h0;
         end else if (frame_end) begin
            if (dly_q[ch] != 2'h0) begin
               dly_d[ch] = dly_q[ch] - 2'h1;
            end else if (skp_q[ch] >= cfg_q.skip[ch]) begin
               skp_d[ch] = 2'h0;
            end else begin
               skp_d[ch] = skp_q[ch] + 2'h1;
            end
         end
         act_d[ch] = (dly_d[ch] == 2'h0) && (skp_d[ch] == 2'h0);
         led_d[ch] = (state_d == LPS_ON) && act_d[ch];
      end

      // A lit output has finished its delay and is in a shown frame
      property p_led_gate;
         @(posedge i_clk) disable iff (i_rst)
         o_led_output[ch] |-> (dly_q[ch] == 2'h0) && (skp_q[ch] == 2'h0);
      endproperty
      a_led_gate: assert property (p_led_gate)
         else $error("output lit while delayed or masked");
   end

   // Registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_q        <= '{toff: LPS_RST_TOFF, ton: LPS_RST_TON, src: LPS_RST_SRC,
                           default: '0};
         en_q         <= 1'b0;
         o_reg_rdata  <= 8'h00;
         pin_s_q      <= 3'h0;
         pin_q        <= 1'b0;
         state_q      <= LPS_IDLE;
         ms_q         <= 14'h0000;
         pulse_q      <= 2'h0;
         dly_q        <= '0;
         skp_q        <= '0;
         o_led_output <= 4'h0;
         o_running    <= 1'b0;
      end else begin
         cfg_q        <= cfg_d;
         en_q         <= en_d;
         o_reg_rdata  <= rdata_d;
         pin_s_q      <= {pin_s_q[1:0], i_trig_pin};
         pin_q        <= pin_d;
         state_q      <= state_d;
         ms_q         <= ms_d;
         pulse_q      <= pulse_d;
         dly_q        <= dly_d;
         skp_q        <= skp_d;
         o_led_output <= led_d;
         o_running    <= (state_d != LPS_IDLE);
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_frame_end;
      (state_q == LPS_OFF) && done;
   endsequence

   property p_idle_dark;
      (state_q == LPS_IDLE) |-> (o_led_output == 4'h0) && !o_running;
   endproperty
   a_idle_dark: assert property (p_idle_dark)
      else $error("outputs active while idle");

   property p_stop_now;
      (state_q != LPS_IDLE) && !run_req && !cfg_q.phase_out |=> (state_q == LPS_IDLE);
   endproperty
   a_stop_now: assert property (p_stop_now)
      else $error("immediate stop did not halt");

   property p_phase_out;
      (state_q != LPS_IDLE) && !(state_q == LPS_OFF && done) && cfg_q.phase_out
         |=> (state_q != LPS_IDLE);
   endproperty
   a_phase_out: assert property (p_phase_out)
      else $error("graceful stop cut the frame short");

   property p_pulse_count;
      (state_q == LPS_ON) && done && (pulse_q != cfg_q.pulses) |=> (state_q != LPS_OFF);
   endproperty
   a_pulse_count: assert property (p_pulse_count)
      else $error("frame ended before all pulses");

   property p_no_zero_pause;
      (state_q == LPS_ON) && done && (pulse_q != cfg_q.pulses) && (cfg_q.gap == 2'h0)
         |=> (state_q != LPS_PAUSE);
   endproperty
   a_no_zero_pause: assert property (p_no_zero_pause)
      else $error("pause entered with zero pause time");

   property p_on_bound;
      (state_q == LPS_ON) && tick && ((ms_q + 14'h0001) >= LPS_ON_MS[cfg_q.ton])
         |=> (ms_q == 14'h0000);
   endproperty
   a_on_bound: assert property (p_on_bound)
      else $error("on-time overran its code");

   property p_off_bound;
      (state_q == LPS_OFF) && tick && ((ms_q + 14'h0001) >= LPS_OFF_MS[cfg_q.toff])
         |=> (ms_q == 14'h0000);
   endproperty
   a_off_bound: assert property (p_off_bound)
      else $error("off-time overran its code");

   property p_new_frame;
      s_frame_end ##0 run_req |=> (state_q == LPS_ON) && (pulse_q == 2'h0);
   endproperty
   a_new_frame: assert property (p_new_frame)
      else $error("next frame did not start with first pulse");

   property p_latch;
      start |=> (dly_q == $past(cfg_q.offset)) && (state_q == LPS_ON);
   endproperty
   a_latch: assert property (p_latch)
      else $error("start delays not latched at start");

   property p_src_sw;
      (state_q == LPS_IDLE) && !cfg_q.src && !en_q |=> (state_q == LPS_IDLE);
   endproperty
   a_src_sw: assert property (p_src_sw)
      else $error("started without the selected trigger");

endmodule
`default_nettype wire

//--- test/lps_top_tb_top.sv
// Self-checking bench for the LED pattern sequencer
`timescale 1ns/10ps
`default_nettype none
module lps_top_tb_top;
   import lps_pkg::*;

   localparam int TC = 2;                  // Shortened tick so all eight codes fit the run

   logic       i_clk;                      // Bench clock
   logic       i_rst;                      // Bench reset
   logic       i_reg_wr;                   // Write strobe
   logic [7:0] i_reg_addr;                 // Offset
   logic [7:0] i_reg_wdata;                // Write data
   logic       i_trig_pin;                 // Trigger pin
   logic [7:0] o_reg_rdata;                // Read data
   logic [3:0] o_led_output;               // Outputs lit
   logic       o_running;                  // Busy flag

   typedef struct {
      int         kind;                    // 0 rdata, 1 outputs, 2 running
      logic [7:0] val;                     // Expected value
   } lps_exp_type;

   lps_exp_type q[$];                      // Expectations in order
   lps_exp_type w_e;                       // Popped entry
   int         n_errors  = 0;              // Mismatch count
   int         cmp_count = 0;              // Compare count
   int         cyc       = 0;              // Rising edges seen
   int         t0        = 0;              // Edge count at run start
   int         c_on, c_gap, c_off, c_p;    // Frame model in cycles
   logic [7:0] c_skip, c_ofs;              // Mask and latched delay fields
   logic [7:0] rv;                         // Random data

   lps_top #(.TICK_CYCLES(TC)) u_dut (
      .i_clk        (i_clk),
      .i_rst        (i_rst),
      .i_reg_wr     (i_reg_wr),
      .i_reg_addr   (i_reg_addr),
      .i_reg_wdata  (i_reg_wdata),
      .i_trig_pin   (i_trig_pin),
      .o_reg_rdata  (o_reg_rdata),
      .o_led_output (o_led_output),
      .o_running    (o_running)
   );

   // 40 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // Edge counter, read only at falling edges so no race
   always @(posedge i_clk) cyc <= cyc + 1;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic note(input int kind, input logic [7:0] val);
      lps_exp_type e;
      e.kind = kind;
      e.val  = val;
      q.push_back(e);
   endtask

   // Watcher: outputs settle just after the edge, so look 2 ns later
   always @(posedge i_clk) begin
      #2;
      while (q.size() > 0) begin
         w_e = q.pop_front();
         case (w_e.kind)
            0: check(o_reg_rdata, w_e.val, "read data");
            1: check({4'h0, o_led_output}, w_e.val, "outputs");
            default: check({7'h00, o_running}, w_e.val, "running");
         endcase
      end
   end

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_reg_wr    = 1'b1;
      i_reg_addr  = a;
      i_reg_wdata = d;
      @(negedge i_clk);
      i_reg_wr    = 1'b0;
   endtask

   // Address sampled at the next edge, data checked right after it
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clk);
      i_reg_addr = a;
      note(0, exp);
   endtask

   task automatic setcfg(input logic [2:0] ton, input logic [2:0] toff, input logic [1:0] p,
                         input logic [1:0] g, input logic [7:0] sk, input logic [7:0] of);
      reg_write(LPS_ADDR_TIMING, {2'h0, toff, ton});
      reg_write(LPS_ADDR_PULSE, {p, 4'h0, g});
      reg_write(LPS_ADDR_SKIP, sk);
      reg_write(LPS_ADDR_OFFSET, of);
      c_on   = int'(LPS_ON_MS[ton]) * TC;
      c_off  = int'(LPS_OFF_MS[toff]) * TC;
      c_gap  = int'(LPS_GAP_MS[g]) * TC;
      c_p    = int'(p) + 1;
      c_skip = sk;
      c_ofs  = of;
   endtask

   // Bounded wait on the busy flag; a start also resets the time base
   task automatic wait_run(input logic v);
      int k;
      k = 0;
      while (o_running !== v && k < 20) begin
         @(negedge i_clk);
         k++;
      end
      note(2, {7'h00, v});
      t0 = cyc;
   endtask

   function automatic int frame_len();
      return c_p * c_on + (c_p - 1) * c_gap + c_off;
   endfunction

   // Expected outputs at cycle t of a run
   function automatic logic [3:0] exp_led(input int t);
      int         f, r, d, m;
      logic       lit;
      logic [3:0] res;
      f   = t / frame_len();
      r   = t % frame_len();
      lit = 1'b0;
      for (int i = 0; i < c_p; i++) begin
         if (r >= i * (c_on + c_gap) && r < i * (c_on + c_gap) + c_on) lit = 1'b1;
      end
      for (int n = 0; n < 4; n++) begin
         d      = int'(c_ofs[2*n +: 2]);
         m      = int'(c_skip[2*n +: 2]);
         res[n] = lit && f >= d && ((f - d) % (m + 1)) == 0;
      end
      return res;
   endfunction

   task automatic go_to(input int t);
      while (cyc - t0 < t) @(negedge i_clk);
   endtask

   task automatic probe(input int t);
      go_to(t);
      note(1, {4'h0, exp_led(t)});
      note(2, 8'h01);
   endtask

   // Probe the middle of every phase, away from edges
   task automatic chk_frames(input int f0, input int n);
      int b;
      for (int f = f0; f < f0 + n; f++) begin
         b = f * frame_len();
         for (int i = 0; i < c_p; i++) begin
            probe(b + i * (c_on + c_gap) + c_on / 2);
            if (c_gap > 0 && i < c_p - 1) probe(b + i * (c_on + c_gap) + c_on + c_gap / 2);
         end
         probe(b + frame_len() - c_off / 2);
      end
   endtask

   // Request falls at the write edge, idle one edge later
   task automatic stop_now();
      reg_write(LPS_ADDR_START, 8'h00);
      @(negedge i_clk);
      note(2, 8'h00);
      note(1, 8'h00);
   endtask

   task automatic wrap_up;
      repeat (3) @(negedge i_clk);
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog: whole run needs about 46k cycles
   initial begin
      repeat (90000) @(posedge i_clk);
      n_errors++;
      $display("Watchdog expired");
      wrap_up();
   end

   initial begin
      i_rst       = 1'b1;
      i_reg_wr    = 1'b0;
      i_reg_addr  = 8'h00;
      i_reg_wdata = 8'h00;
      i_trig_pin  = 1'b0;
      void'($urandom(68153));
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      // Reset values and unmapped place
      reg_write(8'h1D, 8'hFF);
      reg_read(LPS_ADDR_TIMING, 8'h18);
      reg_read(LPS_ADDR_PULSE, 8'h00);
      reg_read(LPS_ADDR_SKIP, 8'h00);
      reg_read(LPS_ADDR_START, 8'h01);
      reg_read(LPS_ADDR_OFFSET, 8'h00);
      reg_read(8'h1D, 8'h00);
      note(2, 8'h00);
      $display("test reset done");
      // Random write and readback; enable bit never reads back
      for (int i = 0; i < 4; i++) begin
         rv = 8'($urandom);
         // Pin stays the source so a random enable bit cannot start a run
         if (i == 2) rv = rv | 8'h01;
         reg_write(LPS_ADDR_PULSE + 8'(i), rv);
         reg_read(LPS_ADDR_PULSE + 8'(i), rv & ((i == 0) ? 8'hC3 : (i == 2) ? 8'h05 : 8'hFF));
      end
      reg_write(LPS_ADDR_START, 8'h00);
      $display("test registers done");
      // Every count, pause, on and off code
      // Long codes run one pulse, code 4 two back to back, to keep the run short
      for (int i = 0; i < 8; i++) begin
         setcfg(3'(i), 3'(i), (i < 4) ? 2'(i) : 2'(i == 4),
                (i < 4) ? 2'(i) : 2'h0, 8'h00, 8'h00);
         reg_write(LPS_ADDR_START, 8'h02);
         wait_run(1'b1);
         chk_frames(0, 1);
         stop_now();
      end
      $display("test pulses done");
      // Masks and delays; delay change waits for a restart
      setcfg(3'h0, 3'h0, 2'h0, 2'h0, 8'h1B, 8'hE4);
      reg_write(LPS_ADDR_START, 8'h02);
      wait_run(1'b1);
      // New delays written while delays still count must not take effect
      reg_write(LPS_ADDR_OFFSET, 8'h1B);
      chk_frames(0, 4);
      chk_frames(4, 4);
      go_to(8 * frame_len() + c_on / 2);
      stop_now();
      rv = 8'($urandom);
      reg_write(LPS_ADDR_SKIP, rv);
      c_skip = rv;
      c_ofs  = 8'h1B;
      reg_write(LPS_ADDR_START, 8'h02);
      wait_run(1'b1);
      chk_frames(0, 4);
      stop_now();
      $display("test masks done");
      // Graceful stop finishes the frame
      setcfg(3'h0, 3'h0, 2'h1, 2'h1, 8'h00, 8'h00);
      reg_write(LPS_ADDR_START, 8'h06);
      wait_run(1'b1);
      probe(c_on / 2);
      reg_write(LPS_ADDR_START, 8'h04);
      chk_frames(0, 1);
      go_to(frame_len() + 10);
      note(2, 8'h00);
      note(1, 8'h00);
      $display("test phase out done");
      // Pin as trigger source; software bit then ignored
      reg_write(LPS_ADDR_START, 8'h03);
      repeat (8) @(negedge i_clk);
      note(2, 8'h00);
      i_trig_pin = 1'b1;
      wait_run(1'b1);
      probe(c_on / 2);
      i_trig_pin = 1'b0;
      wait_run(1'b0);
      reg_write(LPS_ADDR_START, 8'h00);
      i_trig_pin = 1'b1;
      repeat (8) @(negedge i_clk);
      note(2, 8'h00);
      i_trig_pin = 1'b0;
      $display("test trigger done");
      wrap_up();
   end

endmodule
`default_nettype wire
